// ### hw/crc_pkg.sv
// constants and types shared by the continuous recording controller
package crc_pkg;
   // ----------------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CHEN_OFS = 8'h04;
   localparam logic [7:0] HIST_OFS = 8'h08;
   localparam logic [7:0] DUR_OFS = 8'h0c;
   localparam logic [7:0] STAT_OFS = 8'h10;
   localparam logic [7:0] OVCNT_OFS = 8'h14;
   localparam logic [7:0] ELAP_OFS = 8'h18;
   localparam logic [7:0] ADDR_OFS = 8'h1c;
   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_MODE_LSB = 2;
   localparam int STAT_REC_BIT = 0;
   localparam int STAT_SUSP_BIT = 1;
   localparam int STAT_OVR_BIT = 2;
   localparam int STAT_WRAP_BIT = 3;
   localparam int STAT_CAUSE_LSB = 4;
   // ----------------------------------------------------------------------
   // widths, sizes and reset values
   // ----------------------------------------------------------------------
   localparam int NCHAN = 16;
   localparam int SMP_W = 16;
   localparam int CH_W = 4;
   localparam int FIFO_W = 1 + CH_W + SMP_W;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam logic [15:0] CHEN_RST = 16'hffff;
   localparam logic [31:0] HIST_RST = 32'h0000_1000;
   localparam logic [31:0] DUR_RST = 32'h0000_03e8;
   // ----------------------------------------------------------------------
   // timing: one elapsed-time tick per millisecond
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_STANDARD = 2'b00,
      MODE_CIRCULAR = 2'b01,
      MODE_TIMED = 2'b10,
      MODE_TRIGGER = 2'b11
   } crc_mode_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REC = 2'b01,
      ST_SUSP = 2'b10
   } crc_state_e;
   typedef enum logic [2:0] {
      END_NONE = 3'h0,
      END_USER = 3'h1,
      END_MEDIA_FULL = 3'h2,
      END_TRIGGER = 3'h3,
      END_TIME = 3'h4
   } crc_cause_e;
endpackage

// ### hw/crc_fifo_if.sv
// handshake bundle between the controller and its sample fifo
`timescale 1ns/10ps
interface crc_fifo_if;
   logic wr_valid;
   logic wr_ready;
   logic [crc_pkg::FIFO_W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [crc_pkg::FIFO_W-1:0] rd_data;
   logic empty;
   logic full;
   modport ctrl_side (output wr_valid, output wr_data, output rd_ready,
      input wr_ready, input rd_valid, input rd_data, input empty, input full);
   modport fifo_side (input wr_valid, input wr_data, input rd_ready,
      output wr_ready, output rd_valid, output rd_data, output empty, output full);
endinterface

// ### hw/crc_fifo.sv
// first-word-fall-through sample fifo between acquisition and storage
`timescale 1ns/10ps
module crc_fifo (
   input wire logic mclk,
   input wire logic sys_rst,
   crc_fifo_if.fifo_side f
);
   logic [crc_pkg::FIFO_W-1:0] mem [crc_pkg::FIFO_DEPTH];
   logic [crc_pkg::FIFO_AW:0] wptr_ff;
   logic [crc_pkg::FIFO_AW:0] rptr_ff;
   logic do_wr;
   logic do_rd;

   assign f.empty = (wptr_ff == rptr_ff);
   assign f.full = (wptr_ff[crc_pkg::FIFO_AW] != rptr_ff[crc_pkg::FIFO_AW]) &&
      (wptr_ff[crc_pkg::FIFO_AW-1:0] == rptr_ff[crc_pkg::FIFO_AW-1:0]);
   assign f.wr_ready = ~f.full;
   assign f.rd_valid = ~f.empty;
   assign f.rd_data = mem[rptr_ff[crc_pkg::FIFO_AW-1:0]];
   assign do_wr = f.wr_valid & ~f.full;
   assign do_rd = f.rd_ready & ~f.empty;

   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem[wptr_ff[crc_pkg::FIFO_AW-1:0]] <= f.wr_data;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
      end else begin
         if (do_wr) begin
            wptr_ff <= wptr_ff + 1'b1;
         end
         if (do_rd) begin
            rptr_ff <= rptr_ff + 1'b1;
         end
      end
   end
endmodule

// ### hw/crc_tick_div.sv
// divider giving a one-cycle enable pulse every period cycles
`timescale 1ns/10ps
module crc_tick_div #(
   parameter int PERIOD = 100000
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic run,
   output logic tick
);
   logic [31:0] cnt_ff;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_ff <= '0;
         tick <= 1'b0;
      end else if (cnt_ff == 32'(PERIOD - 1)) begin
         cnt_ff <= '0;
         tick <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule

// ### hw/crc_top.sv
// continuous recording controller: modes, stop decisions, fifo and overrun markers
`timescale 1ns/10ps
module crc_top #(
   parameter int TICK_CYCLES = crc_pkg::TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic smp_valid,
   input wire logic [crc_pkg::CH_W-1:0] smp_chan,
   input wire logic [crc_pkg::SMP_W-1:0] smp_data,
   input wire logic sys_trigger,
   input wire logic media_full,
   output logic st_valid,
   input wire logic st_ready,
   output logic st_marker,
   output logic [crc_pkg::CH_W-1:0] st_chan,
   output logic [crc_pkg::SMP_W-1:0] st_data,
   output logic [31:0] st_addr,
   output logic rec_active,
   output logic rec_suspended
);
   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   crc_fifo_if fif ();
   crc_pkg::crc_state_e state_ff;
   crc_pkg::crc_state_e nxt_state;
   crc_pkg::crc_mode_e mode_ff;
   crc_pkg::crc_cause_e cause_ff;
   crc_pkg::crc_cause_e nxt_cause;
   logic [15:0] chen_ff;
   logic [31:0] hist_ff;
   logic [31:0] dur_ff;
   logic [31:0] elapsed_ff;
   logic [31:0] ovcnt_ff;
   logic [31:0] addr_ff;
   logic ovr_ff;
   logic wrap_ff;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic [31:0] rd_mux;
   logic st_valid_ff;
   logic st_marker_ff;
   logic [crc_pkg::CH_W-1:0] st_chan_ff;
   logic [crc_pkg::SMP_W-1:0] st_data_ff;
   logic [31:0] st_addr_ff;
   logic rec_active_ff;
   logic rec_susp_ff;
   logic bus_req;
   logic bus_wr;
   logic start_cmd;
   logic stop_cmd;
   logic ovr_clr;
   logic ms_tick;
   logic recording;
   logic smp_take;
   logic marker_push;
   logic overrun_evt;
   logic st_load;
   logic time_up;

   // ----------------------------------------------------------------------
   // wishbone slave: one wait state, ack for one cycle
   // ----------------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign bus_wr = bus_req & wb_we_i;
   // start and stop are write-one strobes on the low byte of the control word
   assign start_cmd = bus_wr & wb_sel_i[0] & (wb_adr_i == crc_pkg::CTRL_OFS) &
      wb_dat_i[crc_pkg::CTRL_START_BIT];
   assign stop_cmd = bus_wr & wb_sel_i[0] & (wb_adr_i == crc_pkg::CTRL_OFS) &
      wb_dat_i[crc_pkg::CTRL_STOP_BIT];
   assign ovr_clr = bus_wr & wb_sel_i[0] & (wb_adr_i == crc_pkg::STAT_OFS) &
      wb_dat_i[crc_pkg::STAT_OVR_BIT];

   always_comb begin
      rd_mux = 32'h0;
      unique case (wb_adr_i)
         crc_pkg::CTRL_OFS: begin
            rd_mux[crc_pkg::CTRL_MODE_LSB +: 2] = mode_ff;
         end
         crc_pkg::CHEN_OFS: begin
            rd_mux[15:0] = chen_ff;
         end
         crc_pkg::HIST_OFS: begin
            rd_mux = hist_ff;
         end
         crc_pkg::DUR_OFS: begin
            rd_mux = dur_ff;
         end
         crc_pkg::STAT_OFS: begin
            rd_mux[crc_pkg::STAT_REC_BIT] = (state_ff != crc_pkg::ST_IDLE);
            rd_mux[crc_pkg::STAT_SUSP_BIT] = (state_ff == crc_pkg::ST_SUSP);
            rd_mux[crc_pkg::STAT_OVR_BIT] = ovr_ff;
            rd_mux[crc_pkg::STAT_WRAP_BIT] = wrap_ff;
            rd_mux[crc_pkg::STAT_CAUSE_LSB +: 3] = cause_ff;
         end
         crc_pkg::OVCNT_OFS: begin
            rd_mux = ovcnt_ff;
         end
         crc_pkg::ELAP_OFS: begin
            rd_mux = elapsed_ff;
         end
         crc_pkg::ADDR_OFS: begin
            rd_mux = addr_ff;
         end
         default: begin
            rd_mux = 32'h0;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0;
      end else begin
         ack_ff <= bus_req;
         if (bus_req && !wb_we_i) begin
            rdat_ff <= rd_mux;
         end
      end
   end

   // configuration is frozen while a recording runs
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_ff <= crc_pkg::MODE_STANDARD;
         chen_ff <= crc_pkg::CHEN_RST;
         hist_ff <= crc_pkg::HIST_RST;
         dur_ff <= crc_pkg::DUR_RST;
      end else if (bus_wr && state_ff == crc_pkg::ST_IDLE) begin
         if (wb_adr_i == crc_pkg::CTRL_OFS && wb_sel_i[0]) begin
            mode_ff <= crc_pkg::crc_mode_e'(wb_dat_i[crc_pkg::CTRL_MODE_LSB +: 2]);
         end
         if (wb_adr_i == crc_pkg::CHEN_OFS) begin
            if (wb_sel_i[0]) begin
               chen_ff[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               chen_ff[15:8] <= wb_dat_i[15:8];
            end
         end
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b] && wb_adr_i == crc_pkg::HIST_OFS) begin
               hist_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
            if (wb_sel_i[b] && wb_adr_i == crc_pkg::DUR_OFS) begin
               dur_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // elapsed time in milliseconds
   // ----------------------------------------------------------------------
   assign recording = (state_ff != crc_pkg::ST_IDLE);

   crc_tick_div #(
      .PERIOD(TICK_CYCLES)
   ) u_tick (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .run(recording),
      .tick(ms_tick)
   );

   // time keeps running through suspensions; the gap is part of the recording
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         elapsed_ff <= 32'h0;
      end else if (start_cmd && !recording) begin
         elapsed_ff <= 32'h0;
      end else if (recording && ms_tick) begin
         elapsed_ff <= elapsed_ff + 32'h1;
      end
   end

   assign time_up = (elapsed_ff >= dur_ff);

   // ----------------------------------------------------------------------
   // recording state and end decision
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_cause = cause_ff;
      unique case (state_ff)
         crc_pkg::ST_IDLE: begin
            if (start_cmd) begin
               nxt_state = crc_pkg::ST_REC;
               nxt_cause = crc_pkg::END_NONE;
            end
         end
         crc_pkg::ST_REC, crc_pkg::ST_SUSP: begin
            if (state_ff == crc_pkg::ST_REC && fif.full) begin
               nxt_state = crc_pkg::ST_SUSP;
            end else if (state_ff == crc_pkg::ST_SUSP && fif.empty) begin
               nxt_state = crc_pkg::ST_REC;
            end
            unique case (mode_ff)
               crc_pkg::MODE_STANDARD: begin
                  if (media_full) begin
                     nxt_state = crc_pkg::ST_IDLE;
                     nxt_cause = crc_pkg::END_MEDIA_FULL;
                  end
               end
               crc_pkg::MODE_CIRCULAR: begin
                  if (sys_trigger) begin
                     nxt_state = crc_pkg::ST_IDLE;
                     nxt_cause = crc_pkg::END_TRIGGER;
                  end
               end
               crc_pkg::MODE_TIMED: begin
                  if (media_full) begin
                     nxt_state = crc_pkg::ST_IDLE;
                     nxt_cause = crc_pkg::END_MEDIA_FULL;
                  end else if (time_up) begin
                     nxt_state = crc_pkg::ST_IDLE;
                     nxt_cause = crc_pkg::END_TIME;
                  end
               end
               crc_pkg::MODE_TRIGGER: begin
                  if (media_full) begin
                     nxt_state = crc_pkg::ST_IDLE;
                     nxt_cause = crc_pkg::END_MEDIA_FULL;
                  end else if (sys_trigger) begin
                     nxt_state = crc_pkg::ST_IDLE;
                     nxt_cause = crc_pkg::END_TRIGGER;
                  end
               end
            endcase
            // user stop outranks the automatic causes
            if (stop_cmd) begin
               nxt_state = crc_pkg::ST_IDLE;
               nxt_cause = crc_pkg::END_USER;
            end
         end
         default: begin
            nxt_state = crc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= crc_pkg::ST_IDLE;
         cause_ff <= crc_pkg::END_NONE;
      end else begin
         state_ff <= nxt_state;
         cause_ff <= nxt_cause;
      end
   end

   // ----------------------------------------------------------------------
   // fifo write side: samples, or a marker on leaving suspension
   // ----------------------------------------------------------------------
   // the marker is written in the cycle the buffer is seen empty, so it
   // always finds room and sits exactly at the gap in the stream
   assign marker_push = (state_ff == crc_pkg::ST_SUSP) && fif.empty &&
      (nxt_state == crc_pkg::ST_REC);
   assign smp_take = (state_ff == crc_pkg::ST_REC) && smp_valid &&
      chen_ff[smp_chan] && !fif.full;
   assign overrun_evt = (state_ff == crc_pkg::ST_REC) && fif.full;

   crc_fifo u_fifo (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .f(fif.fifo_side)
   );

   always_comb begin
      fif.wr_valid = smp_take | marker_push;
      if (marker_push) begin
         fif.wr_data = {1'b1, {crc_pkg::CH_W{1'b0}}, {crc_pkg::SMP_W{1'b0}}};
      end else begin
         fif.wr_data = {1'b0, smp_chan, smp_data};
      end
   end

   // overrun flag: a new overrun wins over a clear in the same cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ovr_ff <= 1'b0;
         ovcnt_ff <= 32'h0;
      end else begin
         if (overrun_evt) begin
            ovr_ff <= 1'b1;
            ovcnt_ff <= ovcnt_ff + 32'h1;
         end else if (ovr_clr) begin
            ovr_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // storage side: drains in every state, suspended or stopped
   // ----------------------------------------------------------------------
   assign st_load = fif.rd_valid && (!st_valid_ff || st_ready);
   assign fif.rd_ready = st_load;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_valid_ff <= 1'b0;
         st_marker_ff <= 1'b0;
         st_chan_ff <= '0;
         st_data_ff <= '0;
         st_addr_ff <= 32'h0;
      end else if (st_load) begin
         st_valid_ff <= 1'b1;
         st_marker_ff <= fif.rd_data[crc_pkg::FIFO_W-1];
         st_chan_ff <= fif.rd_data[crc_pkg::SMP_W +: crc_pkg::CH_W];
         st_data_ff <= fif.rd_data[crc_pkg::SMP_W-1:0];
         st_addr_ff <= addr_ff;
      end else if (st_ready) begin
         st_valid_ff <= 1'b0;
      end
   end

   // storage address: linear, or wrapped at the history length in circular mode
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_ff <= 32'h0;
         wrap_ff <= 1'b0;
      end else if (start_cmd && !recording) begin
         addr_ff <= 32'h0;
         wrap_ff <= 1'b0;
      end else if (st_load) begin
         if (mode_ff == crc_pkg::MODE_CIRCULAR && addr_ff + 32'h1 >= hist_ff) begin
            addr_ff <= 32'h0;
            wrap_ff <= 1'b1;
         end else begin
            addr_ff <= addr_ff + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // status pins
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rec_active_ff <= 1'b0;
         rec_susp_ff <= 1'b0;
      end else begin
         rec_active_ff <= (nxt_state != crc_pkg::ST_IDLE);
         rec_susp_ff <= (nxt_state == crc_pkg::ST_SUSP);
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign st_valid = st_valid_ff;
   assign st_marker = st_marker_ff;
   assign st_chan = st_chan_ff;
   assign st_data = st_data_ff;
   assign st_addr = st_addr_ff;
   assign rec_active = rec_active_ff;
   assign rec_suspended = rec_susp_ff;
endmodule

// ### tb/crc_top_asserts.sv
// port-level checks for the continuous recording controller
`timescale 1ns/10ps
module crc_top_asserts #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic smp_valid,
   input wire logic [crc_pkg::CH_W-1:0] smp_chan,
   input wire logic [crc_pkg::SMP_W-1:0] smp_data,
   input wire logic sys_trigger,
   input wire logic media_full,
   input wire logic st_valid,
   input wire logic st_ready,
   input wire logic st_marker,
   input wire logic [crc_pkg::CH_W-1:0] st_chan,
   input wire logic [crc_pkg::SMP_W-1:0] st_data,
   input wire logic [31:0] st_addr,
   input wire logic rec_active,
   input wire logic rec_suspended
);
   // mode is snooped from bus writes; config only lands while idle
   logic [1:0] mode_ff;
   logic wr_cfg;
   assign wr_cfg = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
      && wb_adr_i == crc_pkg::CTRL_OFS && !rec_active;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_ff <= 2'h0;
      end else if (wr_cfg) begin
         mode_ff <= wb_dat_i[3:2];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single pulse one cycle after request");
   chk_word_hold: assert property (st_valid && !st_ready |=> st_valid
      && $stable({st_marker, st_chan, st_data, st_addr}))
      else $error("storage word changed before acceptance");
   chk_susp_inside: assert property (rec_suspended |-> rec_active)
      else $error("suspended shown while not recording");
   chk_marker_zero: assert property (st_valid && st_marker |-> st_chan == 0 && st_data == 0)
      else $error("marker word carries sample content");
   chk_resume_mark: assert property ($fell(rec_suspended) && rec_active
      |-> ##[0:40] (st_valid && st_marker))
      else $error("no marker word after resume");
   chk_trig_end: assert property (rec_active && sys_trigger && mode_ff[0]
      |-> ##[1:2] !rec_active)
      else $error("trigger did not end recording");
   chk_std_keeps: assert property (rec_active && mode_ff == 2'h0 && sys_trigger && !media_full
      && !wb_cyc_i |=> rec_active)
      else $error("standard recording ended without stop or full");
   chk_full_end: assert property (rec_active && media_full && mode_ff != 2'h1
      |-> ##[1:2] !rec_active)
      else $error("media full did not end recording");
   chk_circ_full: assert property (rec_active && mode_ff == 2'h1 && media_full && !sys_trigger
      && !wb_cyc_i |=> rec_active)
      else $error("circular recording ended on media full");
endmodule
bind crc_top crc_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);

// ### tb/crc_store_model.sv
// storage medium model: slow acceptor that counts samples and markers
`timescale 1ns/10ps
module crc_store_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic st_valid,
   input wire logic st_marker,
   input wire logic [crc_pkg::SMP_W-1:0] st_data,
   output logic st_ready,
   output int n_smp,
   output int n_mark,
   output logic [crc_pkg::SMP_W-1:0] last_data
);
   // half-rate path even when not stalled, so the fifo really fills
   logic slow_ff;
   assign st_ready = !stall && slow_ff;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         slow_ff <= 1'b0;
         n_smp <= 0;
         n_mark <= 0;
         last_data <= 16'h0;
      end else begin
         slow_ff <= !slow_ff;
         if (st_valid && st_ready && st_marker) begin
            n_mark <= n_mark + 1;
         end else if (st_valid && st_ready) begin
            n_smp <= n_smp + 1;
            last_data <= st_data;
         end
      end
   end
endmodule

// ### tb/crc_top_tb.sv
// self-checking bench for the continuous recording controller
`timescale 1ns/10ps
module crc_top_tb;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h0;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, st_addr, rd;
   logic smp_valid = 1'b0, sys_trigger = 1'b0, media_full = 1'b0, stall = 1'b0;
   logic [3:0] smp_chan = 4'h0, st_chan;
   logic [15:0] smp_data = 16'h0, st_data, last_data;
   logic st_valid, st_ready, st_marker, rec_active, rec_suspended;
   int fail_count = 0, tests_run = 0, n_smp, n_mark, wn, base;
   always #5 mclk = ~mclk;
   crc_top #(.TICK_CYCLES(10)) dut_u (.*);
   crc_store_model store_u (.mclk(mclk), .sys_rst(sys_rst), .stall(stall), .st_valid(st_valid),
      .st_marker(st_marker), .st_data(st_data), .st_ready(st_ready), .n_smp(n_smp),
      .n_mark(n_mark), .last_data(last_data));
   // ----
   // tasks
   // ----
   task automatic test_done;
      $display("compares %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         fail_count++;
         $display("[ERR] %0t wait ran out", $time);
         test_done();
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'h3, we, 4'hf, a, d};
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      tmo(n, 20);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      wb(1'b0, a, 32'h0);
      cmp(rd & m, exp);
   endtask
   task automatic smp(input logic [3:0] c, input logic [15:0] d);
      @(posedge mclk);
      {smp_valid, smp_chan, smp_data} <= {1'b1, c, d};
      @(posedge mclk);
      smp_valid <= 1'b0;
   endtask
   // one-cycle pulse: trigger when t is set, media full otherwise
   task automatic ev(input bit t);
      @(posedge mclk);
      {sys_trigger, media_full} <= t ? 2'h2 : 2'h1;
      @(posedge mclk);
      {sys_trigger, media_full} <= 2'h0;
   endtask
   task automatic wait_low(input bit susp);
      wn = 0;
      while ((susp ? rec_suspended : rec_active) !== 1'b0 && wn < 300) begin
         @(posedge mclk);
         wn++;
      end
      tmo(wn, 300);
   endtask
   task automatic start(input logic [1:0] m);
      wb(1'b1, crc_pkg::CTRL_OFS, {28'h0, m, 2'h1});
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rdc(crc_pkg::CHEN_OFS, 32'hffff, '1);
      rdc(crc_pkg::HIST_OFS, 32'h1000, '1);
      rdc(crc_pkg::DUR_OFS, 32'h3e8, '1);
      rdc(crc_pkg::STAT_OFS, 32'h0, '1);
      rdc(8'h20, 32'h0, '1);
      for (int m = 0; m < 4; m++) begin
         wb(1'b1, crc_pkg::CTRL_OFS, {28'h0, 2'(m), 2'h0});
         rdc(crc_pkg::CTRL_OFS, {28'h0, 2'(m), 2'h0}, '1);
      end
      $display("reset and mode test done");
      wb(1'b1, crc_pkg::CHEN_OFS, 32'h2);
      start(2'h0);
      smp(4'h0, 16'h1234);
      smp(4'h1, 16'h5555);
      ev(1'b1);
      repeat (10) @(posedge mclk);
      cmp(n_smp, 1);
      cmp(st_chan, 4'h1);
      cmp(last_data, 16'h5555);
      cmp(rec_active, 1'b1);
      wb(1'b1, crc_pkg::CTRL_OFS, 32'h2);
      wait_low(1'b0);
      rdc(crc_pkg::STAT_OFS, 32'h10, 32'h77);
      start(2'h0);
      ev(1'b0);
      wait_low(1'b0);
      rdc(crc_pkg::STAT_OFS, 32'h20, 32'h77);
      start(2'h3);
      ev(1'b1);
      wait_low(1'b0);
      rdc(crc_pkg::STAT_OFS, 32'h30, 32'h77);
      $display("standard and trigger test done");
      wb(1'b1, crc_pkg::HIST_OFS, 32'h4);
      start(2'h1);
      for (int i = 0; i < 6; i++) begin
         smp(4'h1, 16'(i));
      end
      ev(1'b0);
      repeat (10) @(posedge mclk);
      cmp(n_smp, 7);
      cmp(st_addr, 32'h1);
      rdc(crc_pkg::ADDR_OFS, 32'h2, '1);
      rdc(crc_pkg::STAT_OFS, 32'h9, 32'hf);
      ev(1'b1);
      wait_low(1'b0);
      rdc(crc_pkg::STAT_OFS, 32'h30, 32'h70);
      $display("circular test done");
      wb(1'b1, crc_pkg::DUR_OFS, 32'h5);
      start(2'h2);
      wait_low(1'b0);
      cmp(wn >= 45 && wn <= 60, 1'b1);
      rdc(crc_pkg::STAT_OFS, 32'h40, 32'h70);
      $display("timed test done");
      start(2'h0);
      base = n_smp;
      @(posedge mclk);
      stall <= 1'b1;
      for (int i = 0; i < 24; i++) begin
         {smp_valid, smp_chan, smp_data} <= {1'b1, 4'h1, 16'(i)};
         @(posedge mclk);
      end
      smp_valid <= 1'b0;
      rdc(crc_pkg::STAT_OFS, 32'h7, 32'h7);
      cmp(n_smp, base);
      @(posedge mclk);
      stall <= 1'b0;
      wait_low(1'b1);
      repeat (40) @(posedge mclk);
      cmp(n_mark, 1);
      cmp(n_smp - base >= 16 && n_smp - base <= 17, 1'b1);
      rdc(crc_pkg::OVCNT_OFS, 32'h1, '1);
      smp(4'h1, 16'h0abc);
      repeat (10) @(posedge mclk);
      cmp(last_data, 16'h0abc);
      wb(1'b1, crc_pkg::STAT_OFS, 32'h4);
      rdc(crc_pkg::STAT_OFS, 32'h1, 32'h7);
      wb(1'b1, crc_pkg::CTRL_OFS, 32'h2);
      wait_low(1'b0);
      $display("overrun test done");
      test_done();
   end
endmodule
